// File: design/tdm_link_if.sv
// two-end link for the tdm backplane
`timescale 1ns/10ps
interface tdm_link_if;
	logic dcl_o, dcl_oe;
	logic fsc_o, fsc_oe;
	logic bcl_o, bcl_oe;
	logic dd_o, dd_oe;
	logic du_o, du_oe;
	logic dd_peer_o, dd_peer_oe;
	logic du_peer_o, du_peer_oe;
	logic pu_dd_oe, pu_du_oe;
	logic ext_dcl, ext_fsc;
	// wired-and resolution with pull-ups
	wire dd_line = !((dd_oe && !dd_o) || (dd_peer_oe && !dd_peer_o));
	wire du_line = !((du_oe && !du_o) || (du_peer_oe && !du_peer_o));
	wire dcl_line = dcl_oe ? dcl_o : ext_dcl;
	wire fsc_line = fsc_oe ? fsc_o : ext_fsc;
	modport dev(
		output dcl_o, dcl_oe, fsc_o, fsc_oe, bcl_o, bcl_oe,
		output dd_o, dd_oe, du_o, du_oe, pu_dd_oe, pu_du_oe,
		input dd_line, du_line, dcl_line, fsc_line
	);
	modport peer(
		output dd_peer_o, dd_peer_oe, du_peer_o, du_peer_oe,
		input dd_line, du_line, dcl_line, fsc_line
	);
endinterface

// File: design/tdm_port_dev.sv
// device end: backplane data port routing and channel access
`timescale 1ns/10ps
module tdm_port_dev (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// events
	output logic sync_irq_o,
	// link
	tdm_link_if.dev link
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] cfg_q, act_q;
	logic [7:0] chan_q [2];
	logic [7:0] bread_q [2];
	logic [7:0] icrd_q [2];
	logic [7:0] txd_q, rxd_q;
	logic irq_q;
	logic [4:0] slot_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q, rx_sh_q;
	logic [4:0] div_q;
	logic dcl_q;
	logic phase_q;
	logic frm_q;
	logic [2:0] sdcl_q, sfsc_q;
	logic [1:0] sdd_q;
	logic dd_on_q, du_on_q, pu_win_q;
	logic dd_out, du_out, dd_en, du_en, bit_val;
	logic [4:0] rel;
	logic inchan;
	wire timing_mode_bit = act_q[tdm_port_pkg::F_SPM];
	wire direction_swap_bit = act_q[tdm_port_pkg::F_IDC];
	wire backplane_off_bit = act_q[tdm_port_pkg::F_IOF];
	wire driver_type_select = act_q[tdm_port_pkg::F_ODS];
	wire [2:0] csel = act_q[tdm_port_pkg::F_CSEL +: 3];
	wire [2:0] dim = act_q[tdm_port_pkg::F_DIM +: 3];
	wire [1:0] cc1 = act_q[tdm_port_pkg::F_C1LO +: 2];
	wire [1:0] cc2 = act_q[tdm_port_pkg::F_C2LO +: 2];
	// ----------------------------------------
	// terminal clock generation and external sampling
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			div_q <= 5'h00;
			dcl_q <= 1'b0;
		end else if (div_q == 5'(tdm_port_pkg::DCL_HALF - 1)) begin
			div_q <= 5'h00;
			dcl_q <= !dcl_q;
		end else begin
			div_q <= div_q + 5'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sdcl_q <= 3'h0;
			sfsc_q <= 3'h0;
			sdd_q <= 2'h3;
		end else begin
			sdcl_q <= {sdcl_q[1:0], link.dcl_line};
			sfsc_q <= {sfsc_q[1:0], link.fsc_line};
			sdd_q <= {sdd_q[0], link.dd_line};
		end
	end
	// one bit per two data clock periods; second rising edge ends bit
	wire dcl_rise = timing_mode_bit ? (sdcl_q[1] && !sdcl_q[2])
		: (div_q == 5'(tdm_port_pkg::DCL_HALF - 1) && !dcl_q);
	wire dcl_fall = timing_mode_bit ? (!sdcl_q[1] && sdcl_q[2])
		: (div_q == 5'(tdm_port_pkg::DCL_HALF - 1) && dcl_q);
	wire bit_end = dcl_rise && phase_q;
	wire last_slot = timing_mode_bit ? (slot_q == 5'(tdm_port_pkg::NONTERM_SLOTS - 1))
		: (slot_q == 5'(tdm_port_pkg::TERM_SLOTS - 1));
	wire frame_end = bit_end && (bit_q == 3'h7) && last_slot;
	wire ext_sync = sfsc_q[1] && !sfsc_q[2];
	// ----------------------------------------
	// bit and slot counters
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			phase_q <= 1'b0;
			bit_q <= 3'h0;
			slot_q <= 5'h00;
			frm_q <= 1'b0;
		end else if (timing_mode_bit && ext_sync) begin
			phase_q <= 1'b0;
			bit_q <= 3'h0;
			slot_q <= 5'h00;
			frm_q <= 1'b1;
		end else begin
			frm_q <= frame_end;
			if (dcl_rise) begin
				phase_q <= !phase_q;
			end
			if (bit_end) begin
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					slot_q <= last_slot ? 5'h00 : slot_q + 5'h01;
				end
			end
		end
	end
	// settings move into use only at a frame boundary
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			act_q <= tdm_port_pkg::CONFIG_RST;
		end else if (frm_q) begin
			act_q <= cfg_q;
		end
	end
	// ----------------------------------------
	// slot ownership
	// ----------------------------------------
	always_comb begin
		rel = slot_q - {csel, 2'b00};
		inchan = (slot_q[4:2] == csel);
		dd_en = 1'b0;
		du_en = 1'b0;
		if (timing_mode_bit) begin
			if (inchan && (rel == tdm_port_pkg::SLOT_MON
				|| rel == tdm_port_pkg::SLOT_CTL)) begin
				du_en = !direction_swap_bit;
				dd_en = direction_swap_bit;
			end
		end else begin
			case (slot_q)
				tdm_port_pkg::SLOT_MON, tdm_port_pkg::SLOT_CTL: begin
					du_en = 1'b1;
				end
				tdm_port_pkg::SLOT_MON1, tdm_port_pkg::SLOT_CI1: begin
					dd_en = !direction_swap_bit;
					du_en = direction_swap_bit;
				end
				tdm_port_pkg::SLOT_IC1: begin
					dd_en = (cc1 == tdm_port_pkg::CC_IC_OUT);
				end
				tdm_port_pkg::SLOT_IC2: begin
					dd_en = (cc2 == tdm_port_pkg::CC_IC_OUT);
				end
				tdm_port_pkg::SLOT_ARB: begin
					dd_en = (dim != 3'h0) && bit_q >= 3'(7 - tdm_port_pkg::ARB_HI)
						&& bit_q <= 3'(7 - tdm_port_pkg::ARB_LO);
				end
				default: begin
					dd_en = 1'b0;
				end
			endcase
		end
	end
	// ----------------------------------------
	// transmit and receive shifters
	// ----------------------------------------
	always_comb begin
		case (slot_q)
			tdm_port_pkg::SLOT_IC1: bit_val = chan_q[0][7 - bit_q];
			tdm_port_pkg::SLOT_IC2: bit_val = chan_q[1][7 - bit_q];
			default: bit_val = sh_q[7 - bit_q];
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sh_q <= 8'hFF;
			rx_sh_q <= 8'h00;
			dd_out <= 1'b1;
			du_out <= 1'b1;
			dd_on_q <= 1'b0;
			du_on_q <= 1'b0;
			pu_win_q <= 1'b0;
		end else begin
			dd_on_q <= dd_en;
			du_on_q <= du_en;
			// window opens at the first falling edge, closes at the second
			if (dcl_fall) begin
				pu_win_q <= !phase_q;
			end
			if (bit_end && bit_q == 3'h7) begin
				sh_q <= txd_q;
			end
			if (dcl_fall && phase_q) begin
				rx_sh_q <= {rx_sh_q[6:0], sdd_q[1]};
			end
			dd_out <= dd_en ? bit_val : 1'b1;
			du_out <= du_en ? bit_val : 1'b1;
		end
	end
	// pull-ups: only between first and second falling edges of a bit
	wire pu_win = !timing_mode_bit && !backplane_off_bit && pu_win_q;
	assign link.dd_o = dd_out;
	assign link.du_o = du_out;
	// open drain drives only zeros; push mode drives all enabled bits
	assign link.dd_oe = !backplane_off_bit && dd_on_q && (driver_type_select || !dd_out);
	assign link.du_oe = !backplane_off_bit && du_on_q && (driver_type_select || !du_out);
	assign link.pu_dd_oe = pu_win && (!dd_on_q || dd_out);
	assign link.pu_du_oe = pu_win && (!du_on_q || du_out);
	assign link.dcl_o = dcl_q;
	assign link.dcl_oe = !timing_mode_bit && !backplane_off_bit;
	assign link.fsc_o = (slot_q == 5'h00) && !timing_mode_bit;
	assign link.fsc_oe = !timing_mode_bit && !backplane_off_bit;
	assign link.bcl_o = phase_q;
	assign link.bcl_oe = !timing_mode_bit && !backplane_off_bit;
	// ----------------------------------------
	// channel capture and frame interrupt
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			bread_q[0] <= 8'h00;
			bread_q[1] <= 8'h00;
			icrd_q[0] <= 8'h00;
			icrd_q[1] <= 8'h00;
			rxd_q <= 8'h00;
		end else if (bit_end && bit_q == 3'h7 && !timing_mode_bit) begin
			case (slot_q)
				tdm_port_pkg::SLOT_B1: bread_q[0] <= rx_sh_q;
				tdm_port_pkg::SLOT_B2: bread_q[1] <= rx_sh_q;
				tdm_port_pkg::SLOT_IC1: icrd_q[0] <= rx_sh_q;
				tdm_port_pkg::SLOT_IC2: icrd_q[1] <= rx_sh_q;
				default: rxd_q <= rx_sh_q;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_q <= 1'b0;
		end else if (frm_q && act_q[tdm_port_pkg::F_STEN] && !timing_mode_bit) begin
			irq_q <= 1'b1;
		end else if (wr_i && addr_i == tdm_port_pkg::REG_CONFIG
			&& wdata_i[tdm_port_pkg::F_ACK]) begin
			irq_q <= 1'b0;
		end
	end
	assign sync_irq_o = irq_q;
	// ----------------------------------------
	// register port
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cfg_q <= tdm_port_pkg::CONFIG_RST;
			chan_q[0] <= 8'hFF;
			chan_q[1] <= 8'hFF;
			txd_q <= 8'hFF;
		end else if (wr_i) begin
			case (addr_i)
				tdm_port_pkg::REG_CONFIG: cfg_q <= {1'b0, wdata_i[14:0]};
				tdm_port_pkg::REG_CHAN1: chan_q[0] <= wdata_i[7:0];
				tdm_port_pkg::REG_CHAN2: chan_q[1] <= wdata_i[7:0];
				tdm_port_pkg::REG_TXDATA: txd_q <= wdata_i[7:0];
				default: txd_q <= txd_q;
			endcase
		end
	end
	// chan reg reads ic in 00/01, b in 11, written value in 10
	function automatic logic [7:0] chan_rd(input logic [1:0] cc,
		input logic [7:0] ic, input logic [7:0] b, input logic [7:0] w);
		case (cc)
			tdm_port_pkg::CC_MONITOR, tdm_port_pkg::CC_IC_OUT: chan_rd = ic;
			tdm_port_pkg::CC_CONST: chan_rd = w;
			default: chan_rd = b;
		endcase
	endfunction
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				tdm_port_pkg::REG_CONFIG: rdata_o <= cfg_q;
				tdm_port_pkg::REG_CHAN1:
					rdata_o <= {8'h00, chan_rd(cc1, icrd_q[0], bread_q[0], chan_q[0])};
				tdm_port_pkg::REG_CHAN2:
					rdata_o <= {8'h00, chan_rd(cc2, icrd_q[1], bread_q[1], chan_q[1])};
				tdm_port_pkg::REG_BREAD1: rdata_o <= {8'h00, bread_q[0]};
				tdm_port_pkg::REG_BREAD2: rdata_o <= {8'h00, bread_q[1]};
				tdm_port_pkg::REG_STATUS: rdata_o <= {11'h000, slot_q == 5'h00, irq_q, timing_mode_bit, backplane_off_bit, direction_swap_bit};
				tdm_port_pkg::REG_RXDATA: rdata_o <= {8'h00, rxd_q};
				default: rdata_o <= 16'h0000;
			endcase
		end
	end
endmodule

// File: design/tdm_port_peer.sv
// far end: layer-1 or peripheral driving and sampling the data pins
`timescale 1ns/10ps
module tdm_port_peer (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// user side
	input wire logic [7:0] dd_byte_i,
	input wire logic [31:0] dd_slot_mask_i,
	output logic [7:0] du_byte_o,
	output logic du_byte_valid_o,
	output logic [4:0] slot_o,
	// link
	tdm_link_if.peer link
);
	// ----------------------------------------
	// sampling of link clock and sync
	// ----------------------------------------
	logic [2:0] sdcl_q, sfsc_q;
	logic [1:0] sdu_q;
	logic phase_q;
	logic [2:0] bit_q;
	logic [4:0] slot_q;
	logic [7:0] sh_q;
	logic dd_q;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sdcl_q <= 3'h0;
			sfsc_q <= 3'h0;
			sdu_q <= 2'h3;
		end else begin
			sdcl_q <= {sdcl_q[1:0], link.dcl_line};
			sfsc_q <= {sfsc_q[1:0], link.fsc_line};
			sdu_q <= {sdu_q[0], link.du_line};
		end
	end
	wire rise = sdcl_q[1] && !sdcl_q[2];
	wire fall = !sdcl_q[1] && sdcl_q[2];
	wire sync = sfsc_q[1] && !sfsc_q[2];
	// ----------------------------------------
	// counters and shifters
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			phase_q <= 1'b0;
			bit_q <= 3'h0;
			slot_q <= 5'h00;
			sh_q <= 8'h00;
			du_byte_o <= 8'h00;
			du_byte_valid_o <= 1'b0;
			dd_q <= 1'b1;
		end else begin
			du_byte_valid_o <= 1'b0;
			if (fall && phase_q) begin
				sh_q <= {sh_q[6:0], sdu_q[1]};
			end
			if (rise) begin
				phase_q <= !phase_q;
				if (phase_q) begin
					bit_q <= bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						slot_q <= slot_q + 5'h01;
						du_byte_o <= sh_q;
						du_byte_valid_o <= 1'b1;
					end
				end
				dd_q <= dd_slot_mask_i[slot_q] ? dd_byte_i[7 - bit_q] : 1'b1;
			end
			// frame sync realigns the counters, overriding the bit step
			if (sync) begin
				phase_q <= 1'b0;
				bit_q <= 3'h0;
				slot_q <= 5'h00;
			end
		end
	end
	assign slot_o = slot_q;
	assign link.dd_peer_o = dd_q;
	assign link.dd_peer_oe = !dd_q;
	assign link.du_peer_o = 1'b1;
	assign link.du_peer_oe = 1'b0;
endmodule

// File: design/tdm_port_pkg.sv
// shared constants for the tdm backplane port routing ends
package tdm_port_pkg;
	// ----------------------------------------
	// frame geometry
	// ----------------------------------------
	localparam int BITS_PER_SLOT = 8;
	localparam int TERM_SLOTS = 12;
	localparam int NONTERM_SLOTS = 32;
	localparam int CHAN_SLOTS = 4;
	localparam logic [4:0] SLOT_B1 = 5'h00;
	localparam logic [4:0] SLOT_B2 = 5'h01;
	localparam logic [4:0] SLOT_MON = 5'h02;
	localparam logic [4:0] SLOT_CTL = 5'h03;
	localparam logic [4:0] SLOT_IC1 = 5'h04;
	localparam logic [4:0] SLOT_IC2 = 5'h05;
	localparam logic [4:0] SLOT_MON1 = 5'h06;
	localparam logic [4:0] SLOT_CI1 = 5'h07;
	localparam logic [4:0] SLOT_ARB = 5'h0B;
	localparam int SG_BIT = 5;
	localparam int ARB_LO = 2;
	localparam int ARB_HI = 5;
	// ----------------------------------------
	// channel connect encodings
	// ----------------------------------------
	localparam logic [1:0] CC_MONITOR = 2'h0;
	localparam logic [1:0] CC_IC_OUT = 2'h1;
	localparam logic [1:0] CC_CONST = 2'h2;
	localparam logic [1:0] CC_LOOP = 2'h3;
	// ----------------------------------------
	// register offsets, device control port
	// ----------------------------------------
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_CHAN1 = 4'h1;
	localparam logic [3:0] REG_CHAN2 = 4'h2;
	localparam logic [3:0] REG_BREAD1 = 4'h3;
	localparam logic [3:0] REG_BREAD2 = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_TXDATA = 4'h6;
	localparam logic [3:0] REG_RXDATA = 4'h7;
	// config field positions
	localparam int F_SPM = 0;
	localparam int F_ODS = 1;
	localparam int F_IDC = 2;
	localparam int F_IOF = 3;
	localparam int F_C1LO = 4;
	localparam int F_C2LO = 6;
	localparam int F_CSEL = 8;
	localparam int F_DIM = 11;
	localparam int F_STEN = 14;
	localparam int F_ACK = 15;
	localparam logic [15:0] CONFIG_RST = 16'h0000;
	// ----------------------------------------
	// timing: terminal data clock is 2x bit rate
	// ----------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int DCL_HZ = 1536000;
	localparam int DCL_HALF = CLK_HZ / (2 * DCL_HZ);
endpackage

// File: sim/tdm_port_properties.sv
// link assertions for the backplane port routing ends
`timescale 1ns/10ps
module tdm_port_properties (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// link signals
	input wire logic dcl_o, dcl_oe, fsc_o, fsc_oe, bcl_oe,
	input wire logic dd_o, dd_oe, du_o, du_oe,
	input wire logic pu_dd_oe, pu_du_oe, dcl_line
);
	localparam int HALF = tdm_port_pkg::DCL_HALF;
	localparam int FRAME = 12 * 8 * 4 * HALF;
	logic [12:0] fc_q;
	logic [5:0] hc_q;
	logic fs_q, dl_q, fv_q, hv_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ----
	// cycles since frame sync rose and since data clock moved
	// ----
	always_ff @(posedge clk_i) begin
		fs_q <= fsc_o;
		if (!rstn_i || !dcl_oe) begin
			fv_q <= 1'b0;
			fc_q <= 13'h0000;
		end else if (fsc_o && !fs_q) begin
			fv_q <= 1'b1;
			fc_q <= 13'h0001;
		end else begin
			fc_q <= fc_q + 13'h0001;
		end
	end
	always_ff @(posedge clk_i) begin
		dl_q <= dcl_o;
		if (!rstn_i || !dcl_oe) begin
			hv_q <= 1'b0;
			hc_q <= 6'h00;
		end else if (dcl_o != dl_q) begin
			hv_q <= 1'b1;
			hc_q <= 6'h01;
		end else begin
			hc_q <= hc_q + 6'h01;
		end
	end
	a_frame_len: assert property (fsc_o && !fs_q && fv_q && dcl_oe |-> fc_q == FRAME)
		else $error("frame length wrong");
	a_dcl_half: assert property (dcl_oe && dcl_o != dl_q && hv_q |-> hc_q == HALF)
		else $error("data clock half period wrong");
	a_clk_group: assert property (dcl_oe == fsc_oe && dcl_oe == bcl_oe)
		else $error("clock enables split");
	a_pu_terminal: assert property (pu_dd_oe || pu_du_oe |-> dcl_oe)
		else $error("pull-up outside terminal timing");
	a_pu_rise_dd: assert property ($rose(pu_dd_oe) |-> !dcl_line [*4])
		else $error("down pull-up rose off falling edge");
	a_pu_move_du: assert property ($changed(pu_du_oe) |-> !dcl_line)
		else $error("up pull-up moved off falling edge");
	a_pu_zero_dd: assert property (pu_dd_oe && dd_oe |-> dd_o)
		else $error("down pull-up on while zero driven");
	a_pu_zero_du: assert property (pu_du_oe && du_oe |-> du_o)
		else $error("up pull-up on while zero driven");
	c_pu: cover property ($rose(pu_dd_oe));
	c_off: cover property ($fell(dcl_oe));
	c_frame: cover property (fsc_o && !fs_q && fv_q);
endmodule

// File: sim/test_tdm_backplane_port_routing.sv
// self-checking bench for the backplane port routing ends
`timescale 1ns/10ps
module test_tdm_backplane_port_routing;
	localparam int FRAME_T = 12 * 8 * 4 * tdm_port_pkg::DCL_HALF;
	localparam int FRAME_N = 32 * 8 * 2 * 8;
	logic clk_i, rstn_i, wr_i, rd_i, sync_irq_o, du_byte_valid_o, bad;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o, rv;
	logic [7:0] dd_byte_i, du_byte_o, tx, p, w;
	logic [31:0] dd_slot_mask_i;
	logic [4:0] slot_o;
	int n_fail = 0, n_checks = 0, timing_mode_bit, driver_type_select, direction_swap_bit, cc, csel;
	tdm_link_if link();
	tdm_port_dev u_tdm_port_dev(.clk_i(clk_i), .rstn_i(rstn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .sync_irq_o(sync_irq_o), .link(link));
	tdm_port_peer u_tdm_port_peer(.clk_i(clk_i), .rstn_i(rstn_i),
		.dd_byte_i(dd_byte_i), .dd_slot_mask_i(dd_slot_mask_i),
		.du_byte_o(du_byte_o), .du_byte_valid_o(du_byte_valid_o),
		.slot_o(slot_o), .link(link));
	tdm_port_properties u_tdm_port_properties(.clk_i(clk_i),
		.rstn_i(rstn_i), .dcl_o(link.dcl_o), .dcl_oe(link.dcl_oe),
		.fsc_o(link.fsc_o), .fsc_oe(link.fsc_oe), .bcl_oe(link.bcl_oe),
		.dd_o(link.dd_o), .dd_oe(link.dd_oe), .du_o(link.du_o),
		.du_oe(link.du_oe), .pu_dd_oe(link.pu_dd_oe),
		.pu_du_oe(link.pu_du_oe), .dcl_line(link.dcl_line));
	// ----
	// clocks, watchdog and verdict
	// ----
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = !clk_i;
	end
	initial begin
		link.ext_dcl = 1'b0;
		link.ext_fsc = 1'b0;
		#7;
		forever begin
			for (int k = 0; k < FRAME_N / 8; k++) begin
				link.ext_fsc = (k == 0);
				#80 link.ext_dcl = 1'b1;
				#80 link.ext_dcl = 1'b0;
			end
		end
	end
	initial begin
		#1960000;
		n_fail++;
		summarize();
	end
	task automatic summarize();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ----
	// compares, register port and model
	// ----
	task automatic cmp16(input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp8(input logic [7:0] g, e);
		cmp16({8'h00, g}, {8'h00, e});
	endtask
	task automatic cmp1(input logic g, e);
		cmp16({15'h0000, g}, {15'h0000, e});
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		rv = rdata_o;
	endtask
	function automatic logic [15:0] cfg(int s, o, d, f, c, ch);
		return 16'(s | (o << 1) | (d << 2) | (f << 3) | (c << 4) | (c << 6)
			| (ch << 8) | (1 << 14));
	endfunction
	// upstream bytes: only the control slots of the own channel carry data
	task automatic scan(input int settle, input int len);
		int s;
		int e;
		repeat (settle) @(posedge clk_i);
		bad = 1'b0;
		repeat (len) begin
			@(negedge clk_i);
			// the peer has already stepped to the next slot
			s = (slot_o == 5'h00) ? (timing_mode_bit ? 31 : 11) : slot_o - 1;
			if (du_byte_valid_o === 1'b1 && cc < 2) begin
				e = ((s == 4 * csel + 2 || s == 4 * csel + 3) && direction_swap_bit == 0) ? tx : 255;
				cmp8(du_byte_o, 8'(e));
			end
			if (direction_swap_bit && timing_mode_bit && link.du_oe === 1'b1 && (driver_type_select || link.du_o !== 1'b1))
				bad = 1'b1;
		end
	endtask
	initial begin
		rstn_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		dd_byte_i = 8'hFF;
		dd_slot_mask_i = 32'h00000000;
		{timing_mode_bit, driver_type_select, direction_swap_bit, csel} = '0;
		void'($urandom(32'h1BC8));
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(tdm_port_pkg::REG_CONFIG);
		cmp16(rv, tdm_port_pkg::CONFIG_RST);
		rd(4'hC);
		cmp16(rv, 16'h0000);
		tx = 8'($urandom_range(254));
		p = 8'($urandom_range(254));
		wr(tdm_port_pkg::REG_TXDATA, {8'h00, tx});
		dd_byte_i <= p;
		dd_slot_mask_i <= 32'h00000003;
		for (cc = 0; cc < 4; cc++) begin
			w = 8'($urandom_range(254));
			wr(tdm_port_pkg::REG_CHAN1, {8'h00, w});
			wr(tdm_port_pkg::REG_CHAN2, {8'h00, w});
			wr(tdm_port_pkg::REG_CONFIG, cfg(0, 0, 0, 0, cc, 0));
			rd(tdm_port_pkg::REG_CONFIG);
			cmp16(rv, cfg(0, 0, 0, 0, cc, 0));
			scan(FRAME_T + 64, FRAME_T);
			rd(tdm_port_pkg::REG_BREAD1);
			if (cc < 3) cmp16(rv, {8'h00, p});
			rd(tdm_port_pkg::REG_CHAN2);
			if (cc < 3) cmp16(rv, {8'h00, (cc != 0) ? w : 8'hFF});
			cmp1(sync_irq_o, 1'b1);
			wr(tdm_port_pkg::REG_CONFIG, cfg(0, 0, 0, 0, cc, 0) | 16'h8000);
			@(negedge clk_i);
			cmp1(sync_irq_o, 1'b0);
		end
		wr(tdm_port_pkg::REG_CONFIG, cfg(0, 0, 0, 1, 0, 0));
		dd_slot_mask_i <= 32'h00000000;
		repeat (2 * FRAME_T) @(posedge clk_i);
		@(negedge clk_i);
		cmp8({3'h0, link.dcl_oe, link.fsc_oe, link.bcl_oe, link.dd_oe,
			link.du_oe}, 8'h00);
		cc = 0;
		timing_mode_bit = 1;
		for (direction_swap_bit = 0; direction_swap_bit < 2; direction_swap_bit++) begin
			csel = $urandom_range(7);
			driver_type_select = $urandom_range(1);
			wr(tdm_port_pkg::REG_CONFIG, cfg(1, driver_type_select, direction_swap_bit, 0, 0, csel));
			scan(FRAME_T + FRAME_N, FRAME_N);
			cmp1(bad, 1'b0);
		end
		summarize();
	end
endmodule
